/* File: hw/dtc_map.vh */
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
// register selects on the 8-bit peripheral bus
`define DTC_SEL_CTRL        1'b0
`define DTC_SEL_STAT        1'b1
`define DTC_CTRL_RESET      8'h00
`define DTC_STAT_RESET      8'h00
`define DTC_CNT_RESET       8'h00
`define DTC_CMP_RESET       8'hFF
// control fields
`define DTC_UPPER_LEVEL_BIT 7
`define DTC_UPPER_CKS_HI    6
`define DTC_UPPER_CKS_LO    4
`define DTC_LOWER_LEVEL_BIT 3
`define DTC_LOWER_CKS_HI    2
`define DTC_LOWER_CKS_LO    0
// status fields
`define DTC_UOVF_BIT        7
`define DTC_UCMF_BIT        6
`define DTC_UOVIE_BIT       5
`define DTC_UCLR_BIT        4
`define DTC_LOVF_BIT        3
`define DTC_LCMF_BIT        2
`define DTC_LOVIE_BIT       1
`define DTC_LCLR_BIT        0
// clock select codes
`define DTC_CKS_DIV32       3'h4
`define DTC_CKS_DIV16       3'h5
`define DTC_CKS_DIV4        3'h6
`define DTC_CKS_SUB4        3'h7
// prescaler counter width
`define DTC_DIV_BITS        5
`endif

/* File: hw/dtc_prescaler.v */
`timescale 1ns/100ps
// free running divider giving one-cycle enables
module dtc_prescaler #(
  parameter WIDTH = 5
) (
  input  wire sys_clk,    // system clock
  input  wire rst_n,      // async reset, active low
  input  wire sub_tick,   // subclock tick, one cycle pulse
  output reg  en_div4,    // system clock / 4
  output reg  en_div16,   // system clock / 16
  output reg  en_div32,   // system clock / 32
  output reg  en_sub4     // subclock / 4
);
  reg [WIDTH-1:0] count;
  reg [1:0]       sub_count;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count     <= {WIDTH{1'b0}};
      sub_count <= 2'h0;
      en_div4   <= 1'b0;
      en_div16  <= 1'b0;
      en_div32  <= 1'b0;
      en_sub4   <= 1'b0;
    end else begin
      count    <= count + 1'b1;
      en_div4  <= (count[1:0] == 2'h3);
      en_div16 <= (count[3:0] == 4'hF);
      en_div32 <= (count == {WIDTH{1'b1}});
      if (sub_tick) begin
        sub_count <= sub_count + 1'b1;
      end
      en_sub4 <= sub_tick && (sub_count == 2'h3);
    end
  end
endmodule // dtc_prescaler

/* File: hw/dtc_event_edge.v */
`timescale 1ns/100ps
// event pin edge detector with pin-function gating
module dtc_event_edge (
  input  wire sys_clk,        // system clock
  input  wire rst_n,          // async reset, active low
  input  wire event_input_pin, // external event level
  input  wire event_edge_select, // 1 rising, 0 falling
  input  wire event_pin_function_bit, // 1 pin is event input
  output wire event_pulse     // one-cycle count request
);
  reg pin_q;
  reg func_q;
  wire eff_now;
  wire eff_prev;

  // a non-event pin reads as high, so enabling it over a low pin looks like a fall
  assign eff_now  = event_pin_function_bit ? event_input_pin : 1'b1;
  assign eff_prev = func_q ? pin_q : 1'b1;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q  <= 1'b1;
      func_q <= 1'b0;
    end else begin
      pin_q  <= event_input_pin;
      func_q <= event_pin_function_bit;
    end
  end

  assign event_pulse = event_edge_select ? (eff_now & ~eff_prev) : (~eff_now & eff_prev); // RQ8
endmodule // dtc_event_edge

/* File: hw/dtc_timer.v */
`timescale 1ns/100ps
`include "dtc_map.vh"
//
// Contract
// RQ1: write-only control, resets zero: cascaded, events, low
// RQ2: control bit 7 sets upper pin immediately
// RQ3: control bit 3 sets lower pin immediately
// RQ4: upper codes 000/001 cascade; 010/011 forbidden
// RQ5: upper codes 1xx: divide 32,16,4, sub/4
// RQ6: lower codes 000/001 count chosen event edge
// RQ7: lower codes 1xx: divide 32,16,4, sub/4
// RQ8: enabling event pin while low may count
// RQ9: status register readable, writable, resets zero
// RQ10: bit 7 set on upper wrap
// RQ11: flags set only by hardware
// RQ12: clear flag: read one, then write zero
// RQ13: bit 6 set on upper match
// RQ14: bit 5 gates upper overflow request
// RQ15: bit 4 clears counter on match
// RQ16: bit 3 set on lower wrap
// RQ17: bit 2 set on lower match
// RQ18: bit 1 gates lower overflow request
// RQ19: bit 0 clears lower counter on match
// RQ20: cascaded mode: upper flag on 16-bit wrap
// RQ21: match toggles pin from written level
// RQ22: match signalled as counter leaves match value
// RQ23: zero write clears only after read-as-one
//
module dtc_timer #(
  parameter CW = 8
) (
  input  wire          sys_clk,             // system clock, 50 MHz
  input  wire          rst_n,               // async reset, active low
  input  wire          reg_sel,             // 0 control, 1 status
  input  wire          reg_wr,              // write strobe
  input  wire          reg_rd,              // read strobe
  input  wire [7:0]    reg_wdata,           // write data
  output reg  [7:0]    reg_rdata,           // read data
  input  wire [CW-1:0] upper_compare_value, // upper compare register
  input  wire [CW-1:0] lower_compare_value, // lower compare register
  input  wire          sub_tick,            // subclock tick pulse
  input  wire          event_input_pin,     // external event pin
  input  wire          event_edge_select,   // 1 rising edge
  input  wire          event_pin_function_bit, // pin works as event input
  output reg           upper_toggle_pin,    // upper toggle output
  output reg           lower_toggle_pin,    // lower toggle output
  output reg  [CW-1:0] upper_counter,       // upper counter value
  output reg  [CW-1:0] lower_counter,       // lower counter value
  output wire          upper_overflow_irq,  // gated upper overflow request
  output wire          lower_overflow_irq,  // gated lower overflow request
  output wire          upper_match_irq,     // upper match flag level
  output wire          lower_match_irq      // lower match flag level
);
  reg  [7:0] timer_clock_output_control;
  reg  [7:0] timer_flag_status_control;
  reg  [3:0] flag_armed;  // per flag: read as one since last set
  wire       en_div4;
  wire       en_div16;
  wire       en_div32;
  wire       en_sub4;
  wire       event_pulse;

  wire [2:0] upper_cks = timer_clock_output_control[`DTC_UPPER_CKS_HI:`DTC_UPPER_CKS_LO];
  wire [2:0] lower_cks = timer_clock_output_control[`DTC_LOWER_CKS_HI:`DTC_LOWER_CKS_LO];
  wire       split     = upper_cks[2]; // RQ4
  wire       upper_clear_on_match = timer_flag_status_control[`DTC_UCLR_BIT];
  wire       lower_clear_on_match = timer_flag_status_control[`DTC_LCLR_BIT];

  dtc_prescaler #(.WIDTH(`DTC_DIV_BITS)) u_pre (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .sub_tick (sub_tick),
    .en_div4  (en_div4),
    .en_div16 (en_div16),
    .en_div32 (en_div32),
    .en_sub4  (en_sub4)
  );

  dtc_event_edge u_evt (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .event_input_pin        (event_input_pin),
    .event_edge_select      (event_edge_select),
    .event_pin_function_bit (event_pin_function_bit),
    .event_pulse            (event_pulse)
  );

  function clk_pick;
    input [2:0] cks;
    input       d4;
    input       d16;
    input       d32;
    input       s4;
    input       ext;
    begin
      case (cks)
        `DTC_CKS_DIV32: clk_pick = d32;
        `DTC_CKS_DIV16: clk_pick = d16;
        `DTC_CKS_DIV4:  clk_pick = d4;
        `DTC_CKS_SUB4:  clk_pick = s4;
        default:        clk_pick = ext;
      endcase
    end
  endfunction

  wire lower_tick = clk_pick(lower_cks, en_div4, en_div16, en_div32, en_sub4, event_pulse); // RQ6 RQ7
  wire upper_int  = clk_pick(upper_cks, en_div4, en_div16, en_div32, en_sub4, 1'b0);        // RQ5

  // match is signalled on the tick that moves the counter off the matching value
  wire lower_eq    = (lower_counter == lower_compare_value);
  wire upper_eq    = (upper_counter == upper_compare_value);
  wire lower_carry = lower_tick && (lower_counter == {CW{1'b1}});
  wire upper_tick  = split ? upper_int : lower_carry; // RQ4
  wire upper_carry = upper_tick && (upper_counter == {CW{1'b1}});

  wire match16     = !split && lower_tick && lower_eq && upper_eq;
  wire lower_match = split && lower_tick && lower_eq;  // RQ17 RQ22
  wire upper_match = split ? (upper_tick && upper_eq) : match16; // RQ13 RQ22
  wire lower_ovf   = lower_carry && !(split && lower_match && lower_clear_on_match); // RQ16
  wire upper_ovf   = upper_carry && !(upper_match && upper_clear_on_match); // RQ10 RQ20

  // counters
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lower_counter <= `DTC_CNT_RESET;
      upper_counter <= `DTC_CNT_RESET;
    end else begin
      if (!split && match16 && upper_clear_on_match) begin
        lower_counter <= {CW{1'b0}}; // RQ15
        upper_counter <= {CW{1'b0}}; // RQ15
      end else begin
        if (lower_match && lower_clear_on_match) begin
          lower_counter <= {CW{1'b0}}; // RQ19
        end else if (lower_tick) begin
          lower_counter <= lower_counter + 1'b1;
        end
        if (split && upper_match && upper_clear_on_match) begin
          upper_counter <= {CW{1'b0}}; // RQ15
        end else if (upper_tick) begin
          upper_counter <= upper_counter + 1'b1;
        end
      end
    end
  end

  // control register and toggle pins
  wire ctrl_wr = reg_wr && (reg_sel == `DTC_SEL_CTRL);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_clock_output_control <= `DTC_CTRL_RESET; // RQ1
      upper_toggle_pin           <= 1'b0;
      lower_toggle_pin           <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        timer_clock_output_control <= reg_wdata;
        upper_toggle_pin <= reg_wdata[`DTC_UPPER_LEVEL_BIT]; // RQ2
        lower_toggle_pin <= reg_wdata[`DTC_LOWER_LEVEL_BIT]; // RQ3
      end else begin
        if (upper_match) begin
          upper_toggle_pin <= ~upper_toggle_pin; // RQ21
        end
        if (lower_match) begin
          lower_toggle_pin <= ~lower_toggle_pin; // RQ21
        end
      end
    end
  end

  // status register: flags 7,6,3,2 and controls 5,4,1,0
  wire       stat_wr  = reg_wr && (reg_sel == `DTC_SEL_STAT);
  wire       stat_rd  = reg_rd && (reg_sel == `DTC_SEL_STAT);
  wire [3:0] flag_set = {upper_ovf, upper_match, lower_ovf, lower_match};
  wire [3:0] flag_cur = {timer_flag_status_control[`DTC_UOVF_BIT], timer_flag_status_control[`DTC_UCMF_BIT],
                         timer_flag_status_control[`DTC_LOVF_BIT], timer_flag_status_control[`DTC_LCMF_BIT]};
  wire [3:0] flag_wd  = {reg_wdata[`DTC_UOVF_BIT], reg_wdata[`DTC_UCMF_BIT],
                         reg_wdata[`DTC_LOVF_BIT], reg_wdata[`DTC_LCMF_BIT]};
  // a one write leaves the flag alone; set beats clear
  wire [3:0] flag_clr = (stat_wr ? (~flag_wd & flag_armed) : 4'h0);  // RQ11 RQ12 RQ23
  wire [3:0] next_flag = flag_set | (flag_cur & ~flag_clr);          // RQ11

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_flag_status_control <= `DTC_STAT_RESET; // RQ9
      flag_armed                <= 4'h0;
    end else begin
      timer_flag_status_control[`DTC_UOVF_BIT] <= next_flag[3];
      timer_flag_status_control[`DTC_UCMF_BIT] <= next_flag[2];
      timer_flag_status_control[`DTC_LOVF_BIT] <= next_flag[1];
      timer_flag_status_control[`DTC_LCMF_BIT] <= next_flag[0];
      if (stat_wr) begin
        timer_flag_status_control[`DTC_UOVIE_BIT] <= reg_wdata[`DTC_UOVIE_BIT];
        timer_flag_status_control[`DTC_UCLR_BIT]  <= reg_wdata[`DTC_UCLR_BIT];
        timer_flag_status_control[`DTC_LOVIE_BIT] <= reg_wdata[`DTC_LOVIE_BIT];
        timer_flag_status_control[`DTC_LCLR_BIT]  <= reg_wdata[`DTC_LCLR_BIT];
      end
      // arming: read-as-one arms; a new set or a clear disarms
      flag_armed <= ((flag_armed | (stat_rd ? flag_cur : 4'h0)) & ~flag_set & ~flag_clr); // RQ23
    end
  end

  // read data; control register reads as zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= (reg_sel == `DTC_SEL_STAT) ? timer_flag_status_control : 8'h00; // RQ1
    end
  end

  assign upper_overflow_irq = timer_flag_status_control[`DTC_UOVF_BIT] &
                              timer_flag_status_control[`DTC_UOVIE_BIT]; // RQ14
  assign lower_overflow_irq = timer_flag_status_control[`DTC_LOVF_BIT] &
                              timer_flag_status_control[`DTC_LOVIE_BIT]; // RQ18
  assign upper_match_irq    = timer_flag_status_control[`DTC_UCMF_BIT];
  assign lower_match_irq    = timer_flag_status_control[`DTC_LCMF_BIT];
endmodule // dtc_timer

/* File: verification/dtc_timer_assertions.sv */
`timescale 1ns/100ps
module dtc_timer_checker #(
  parameter CW = 8
) (
  input wire          sys_clk,             // clock
  input wire          rst_n,               // reset
  input wire          reg_sel,             // select
  input wire          reg_wr,              // write
  input wire [7:0]    reg_wdata,           // wdata
  input wire [7:0]    reg_rdata,           // rdata
  input wire [CW-1:0] upper_compare_value, // cmp
  input wire [CW-1:0] lower_compare_value, // cmp
  input wire          upper_toggle_pin,    // pin
  input wire          lower_toggle_pin,    // pin
  input wire [CW-1:0] upper_counter,       // count
  input wire [CW-1:0] lower_counter,       // count
  input wire          upper_overflow_irq,  // irq
  input wire          lower_overflow_irq,  // irq
  input wire          upper_match_irq,     // flag
  input wire          lower_match_irq      // flag
);
  reg [7:0] st_w; // last status write
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      st_w <= 8'h00;
    else if (reg_wr && reg_sel)
      st_w <= reg_wdata;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rst;
    $rose(rst_n) |-> reg_rdata == 8'h00 && upper_counter == 0 && lower_counter == 0
      && !upper_toggle_pin && !lower_toggle_pin;
  endproperty
  a_rst: assert property (p_rst) else $error("not zero after reset");
  property p_ulev;
    reg_wr && !reg_sel |=> upper_toggle_pin == $past(reg_wdata[7]);
  endproperty
  a_ulev: assert property (p_ulev) else $error("upper level");
  property p_llev;
    reg_wr && !reg_sel |=> lower_toggle_pin == $past(reg_wdata[3]);
  endproperty
  a_llev: assert property (p_llev) else $error("lower level");
  property p_umv;
    $rose(upper_match_irq) |-> $past(upper_counter) == $past(upper_compare_value);
  endproperty
  a_umv: assert property (p_umv) else $error("upper match value");
  property p_lmv;
    $rose(lower_match_irq) |-> $past(lower_counter) == $past(lower_compare_value);
  endproperty
  a_lmv: assert property (p_lmv) else $error("lower match value");
  property p_utog;
    $rose(upper_match_irq) && (!$past(reg_wr) || $past(reg_sel)) |-> upper_toggle_pin != $past(upper_toggle_pin);
  endproperty
  a_utog: assert property (p_utog) else $error("upper toggle");
  property p_uclr;
    $rose(upper_match_irq) && $past(st_w[4]) |-> upper_counter == 0;
  endproperty
  a_uclr: assert property (p_uclr) else $error("upper clear");
  property p_uovf;
    $rose(upper_overflow_irq) && $past(st_w[5]) |-> $past(upper_counter) == 8'hFF && upper_counter == 0;
  endproperty
  a_uovf: assert property (p_uovf) else $error("upper wrap");
  property p_lovf;
    $rose(lower_overflow_irq) && $past(st_w[1]) |-> $past(lower_counter) == 8'hFF && lower_counter == 0;
  endproperty
  a_lovf: assert property (p_lovf) else $error("lower wrap");
  property p_ugate;
    upper_overflow_irq |-> st_w[5];
  endproperty
  a_ugate: assert property (p_ugate) else $error("upper gate");
  c_umatch: cover property ($rose(upper_match_irq));
  c_lovf: cover property ($rose(lower_overflow_irq));
  c_ctrl: cover property (reg_wr && !reg_sel);
endmodule // dtc_timer_checker
bind dtc_timer dtc_timer_checker #(.CW(CW)) u_chk (
  .sys_clk             (sys_clk),
  .rst_n               (rst_n),
  .reg_sel             (reg_sel),
  .reg_wr              (reg_wr),
  .reg_wdata           (reg_wdata),
  .reg_rdata           (reg_rdata),
  .upper_compare_value (upper_compare_value),
  .lower_compare_value (lower_compare_value),
  .upper_toggle_pin    (upper_toggle_pin),
  .lower_toggle_pin    (lower_toggle_pin),
  .upper_counter       (upper_counter),
  .lower_counter       (lower_counter),
  .upper_overflow_irq  (upper_overflow_irq),
  .lower_overflow_irq  (lower_overflow_irq),
  .upper_match_irq     (upper_match_irq),
  .lower_match_irq     (lower_match_irq)
);

/* File: verification/tb.sv */
`timescale 1ns/100ps
module tb;
  reg        sys_clk = 1'b0, rst_n = 1'b0, reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg        sub_tick = 1'b0, event_input_pin = 1'b0, event_edge_select = 1'b0, event_pin_function_bit = 1'b0;
  reg  [7:0] reg_wdata = 8'h00, upper_compare_value = 8'h20, lower_compare_value = 8'h20;
  reg  [7:0] r, u0, l0, ex;
  reg  [1:0] sdiv = 2'h0;
  wire [7:0] reg_rdata, upper_counter, lower_counter;
  wire       upper_toggle_pin, lower_toggle_pin, upper_overflow_irq, lower_overflow_irq;
  wire       upper_match_irq, lower_match_irq;
  integer    err_count = 0, checks_done = 0, i;
  dtc_timer dut (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .reg_sel                (reg_sel),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_wdata              (reg_wdata),
    .reg_rdata              (reg_rdata),
    .upper_compare_value    (upper_compare_value),
    .lower_compare_value    (lower_compare_value),
    .sub_tick               (sub_tick),
    .event_input_pin        (event_input_pin),
    .event_edge_select      (event_edge_select),
    .event_pin_function_bit (event_pin_function_bit),
    .upper_toggle_pin       (upper_toggle_pin),
    .lower_toggle_pin       (lower_toggle_pin),
    .upper_counter          (upper_counter),
    .lower_counter          (lower_counter),
    .upper_overflow_irq     (upper_overflow_irq),
    .lower_overflow_irq     (lower_overflow_irq),
    .upper_match_irq        (upper_match_irq),
    .lower_match_irq        (lower_match_irq)
  );
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    sdiv <= (sdiv == 2'h2) ? 2'h0 : sdiv + 2'h1;
    sub_tick <= (sdiv == 2'h2);
  end
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_count = err_count + 1;
    end
  endtask
  task wr(input s, input [7:0] d);
    @(posedge sys_clk);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input s, output [7:0] d);
    @(posedge sys_clk);
    reg_sel <= s;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
  endtask
  // pulses two cycles high, two low
  task ev(input integer n);
    repeat (n) begin
      event_input_pin <= 1'b1;
      tick(2);
      event_input_pin <= 1'b0;
      tick(2);
    end
    tick(4);
  endtask
  task results;
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    tick(20000);
    err_count = err_count + 1;
    results;
  end
  initial begin
    tick(20);
    rst_n <= 1'b1;
    rd(1'b1, r);
    chk("status", 8'h00, r);
    rd(1'b0, r);
    chk("control", 8'h00, r);
    chk("pins", 8'h00, {6'h00, upper_toggle_pin, lower_toggle_pin});
    wr(1'b0, 8'h80);
    chk("upper pin", 8'h02, {6'h00, upper_toggle_pin, lower_toggle_pin});
    wr(1'b0, 8'h08);
    chk("lower pin", 8'h01, {6'h00, upper_toggle_pin, lower_toggle_pin});
    tick(1);
    event_pin_function_bit <= 1'b1;
    tick(6);
    chk("spurious", 8'h01, lower_counter);
    ev(5);
    chk("falling", 8'h06, lower_counter);
    event_edge_select <= 1'b1;
    ev(3);
    chk("rising", 8'h09, lower_counter);
    chk("upper idle", 8'h00, upper_counter);
    for (i = 4; i < 8; i = i + 1) begin
      wr(1'b0, {1'b0, i[2:0], 1'b0, i[2:0]});
      u0 = upper_counter;
      l0 = lower_counter;
      ex = (i == 4) ? 8'h06 : (i == 5) ? 8'h0C : (i == 6) ? 8'h30 : 8'h10;
      tick(192);
      #1;
      chk("upper rate", u0 + ex, upper_counter);
      chk("lower rate", l0 + ex, lower_counter);
    end
    wr(1'b0, 8'h66);
    wr(1'b1, 8'h22);
    tick(1100);
    // event mode with a quiet pin freezes both halves
    wr(1'b0, 8'h00);
    tick(4);
    wr(1'b1, 8'hEE);
    chk("irq", 8'h03, {6'h00, upper_overflow_irq, lower_overflow_irq});
    wr(1'b1, 8'h00);
    chk("irq masked", 8'h00, {6'h00, upper_overflow_irq, lower_overflow_irq});
    rd(1'b1, r);
    chk("flags kept", 8'hCC, r);
    wr(1'b1, 8'h33);
    rd(1'b1, r);
    chk("flags cleared", 8'h33, r);
    wr(1'b1, 8'hFF);
    rd(1'b1, r);
    chk("flags not set", 8'h33, r);
    wr(1'b0, 8'hEE);
    chk("levels", 8'h03, {6'h00, upper_toggle_pin, lower_toggle_pin});
    tick(1100);
    for (i = 0; i < 140; i = i + 1) begin
      tick(1);
      chk("upper clear", 8'h00, {7'h00, upper_counter > upper_compare_value});
      chk("lower clear", 8'h00, {7'h00, lower_counter > lower_compare_value});
    end
    // clear old flags, then park the upper half at all ones on sub/4
    rd(1'b1, r);
    wr(1'b1, 8'h20);
    wr(1'b0, 8'h76);
    for (i = 0; i < 3200 && upper_counter !== 8'hFF; i = i + 1)
      tick(1);
    chk("upper top", 8'hFF, upper_counter);
    wr(1'b0, 8'h06);
    u0 = upper_counter;
    l0 = lower_counter;
    tick(1024);
    #1;
    chk("cascade upper", u0 + 8'h01, upper_counter);
    chk("cascade lower", l0, lower_counter);
    rd(1'b1, r);
    chk("cascade wrap", 8'h80, r & 8'h80);
    tick(1);
    upper_compare_value <= 8'h01;
    wr(1'b1, 8'h10);
    tick(1300);
    for (i = 0; i < 20; i = i + 1) begin
      tick(1);
      chk("cascade clear", 8'h00, {7'h00, {upper_counter, lower_counter} > 16'h0120});
    end
    results;
  end
endmodule // tb
